// [rtl/ddcv_pkg.sv]
package ddcv_pkg;
	// --------------------------------------------------------------------
	// widths
	// --------------------------------------------------------------------
	localparam int unsigned SMP_W  = 14;   // converter sample width
	localparam int unsigned DAT_W  = 20;   // internal arithmetic width
	localparam int unsigned ACC_W  = 26;   // accumulator, 20 bits + log2(32) + 1 spare
	localparam int unsigned FIFO_D = 16;   // output buffer depth
	localparam int unsigned ADDR_W = 8;    // register address width
	localparam int unsigned LVL_W  = 5;    // buffer level width
	// --------------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;  // control word
	localparam logic [7:0] ADDR_NCO     = 8'h04;  // pending tuning word
	localparam logic [7:0] ADDR_NCO_ACT = 8'h08;  // active tuning word, read only
	localparam logic [7:0] ADDR_STAT    = 8'h0C;  // status, read only
	// --------------------------------------------------------------------
	// control field positions
	// --------------------------------------------------------------------
	localparam int unsigned C_EN      = 0;   // converter path enable
	localparam int unsigned C_REAL    = 1;   // real decimation
	localparam int unsigned C_FS4     = 2;   // alternating output sign flip, complex mode only
	localparam int unsigned C_GAIN    = 3;   // digital gain enable
	localparam int unsigned C_SWAP    = 4;   // channel swap
	localparam int unsigned C_INV     = 5;   // mixer phase invert
	localparam int unsigned C_NEGX    = 6;   // negative exponential
	localparam int unsigned C_SYNCEN  = 7;   // align pin acts as sync
	localparam int unsigned C_RESTART = 8;   // mixer restart, self clearing
	localparam int unsigned C_DEC     = 12;  // decimation code, 3 bits
	localparam int unsigned C_RES     = 16;  // output resolution, 5 bits
	// --------------------------------------------------------------------
	// reset values and answers
	// --------------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0014_0000;  // off, by 2, 20 bits
	localparam logic [31:0] NCO_RST  = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_DEC = 2'h3;
	localparam logic [4:0]  RES_MIN  = 5'h0E;  // 14 bits
	localparam logic [4:0]  RES_MAX  = 5'h14;  // 20 bits
	localparam logic [2:0]  DEC_MAX  = 3'h4;   // code of decimate by 32
endpackage

// [rtl/ddcv_top.sv]
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ddcv_fifo #(
	parameter int unsigned W     = 40,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [W-1:0]               in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [W-1:0]                    out_data_o,
	output logic [$clog2(DEPTH+1)-1:0]      level_o
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);
	// --------------------------------------------------------------------
	// state: storage plus a registered head word
	// --------------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;  // storage
		logic [PW-1:0]           wp;   // write pointer
		logic [PW-1:0]           rp;   // read pointer
		logic [CW-1:0]           cnt;  // words in storage
		logic                    ov;   // head word valid
		logic [W-1:0]            od;   // head word
	} ddcv_fifo_s;
	ddcv_fifo_s r_reg, r_next;
	logic push, pop;

	// next state: head register refills whenever it is free
	always_comb begin
		r_next = r_reg;
		push   = in_valid_i && (r_reg.cnt != CW'(DEPTH));
		pop    = (r_reg.cnt != '0) && (!r_reg.ov || out_ready_i);
		if (out_ready_i) begin
			r_next.ov = 1'b0;
		end
		if (pop) begin
			r_next.ov = 1'b1;
			r_next.od = r_reg.mem[r_reg.rp];
			r_next.rp = r_reg.rp + 1'b1;
		end
		if (push) begin
			r_next.mem[r_reg.wp] = in_data_i;
			r_next.wp            = r_reg.wp + 1'b1;
		end
		r_next.cnt = r_reg.cnt + CW'(push) - CW'(pop);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign in_ready_o  = (r_reg.cnt != CW'(DEPTH));
	assign out_valid_o = r_reg.ov;
	assign out_data_o  = r_reg.od;
	assign level_o     = r_reg.cnt;
endmodule // ddcv_fifo

`timescale 1ns/100ps
module ddcv_top
	import ddcv_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [ADDR_W-1:0] awaddr_i,
	input  wire logic              awvalid_i,
	output logic                   awready_o,
	input  wire logic [31:0]       wdata_i,
	input  wire logic [3:0]        wstrb_i,
	input  wire logic              wvalid_i,
	output logic                   wready_o,
	output logic [1:0]             bresp_o,
	output logic                   bvalid_o,
	input  wire logic              bready_i,
	input  wire logic [ADDR_W-1:0] araddr_i,
	input  wire logic              arvalid_i,
	output logic                   arready_o,
	output logic [31:0]            rdata_o,
	output logic [1:0]             rresp_o,
	output logic                   rvalid_o,
	input  wire logic              rready_i,
	input  wire logic [SMP_W-1:0]  sample_a_i,
	input  wire logic [SMP_W-1:0]  sample_b_i,
	input  wire logic              sample_valid_i,
	output logic                   sample_ready_o,
	input  wire logic              powerdown_align_pin_i,
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic [DAT_W-1:0]       out_i_o,
	output logic [DAT_W-1:0]       out_q_o
);
	// --------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------
	typedef struct packed {
		logic              awrdy, wrdy, ardy;  // bus ready flags
		logic              aw_got, w_got;      // write halves held
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [31:0]       ctrl;               // control word
		logic [31:0]       nco_pend;           // written tuning word
		logic [31:0]       nco_act;            // word in use
		logic [31:0]       phase;              // phase accumulator
		logic              restart;            // restart pulse
		logic              align_prev;         // pin level last cycle
		logic [4:0]        dcnt;               // samples in window
		logic [ACC_W-1:0]  acc_i, acc_q;       // window sums
		logic              fs4_k;              // output sign alternation
		logic              rdy;                // sample ready
		logic              push_v;             // buffer write
		logic [2*DAT_W-1:0] push_d;            // {q, i}
	} ddcv_s;
	ddcv_s r_reg, r_next;

	logic [LVL_W-1:0] lvl;          // buffer level
	logic             fifo_rdy;     // buffer room
	logic             take;         // sample accepted
	logic             align_evt;    // sync pin rising edge
	logic             restart_evt;  // restart or sync

	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[8*b +: 8] = d[8*b +: 8];
			end
		end
		return m;
	endfunction

	// 16-step sine, amplitude 127; cosine is the same table shifted
	function automatic logic signed [7:0] sine(input logic [3:0] p);
		logic signed [7:0] v;
		unique case (p[1:0])
			2'h0: v = 8'sh00;
			2'h1: v = 8'sh31;
			2'h2: v = 8'sh5A;
			2'h3: v = 8'sh75;
		endcase
		if (p[2]) begin
			v = p[1:0] == 2'h0 ? 8'sh7F : (p[1:0] == 2'h1 ? 8'sh75 : (p[1:0] == 2'h2 ?
				8'sh5A : 8'sh31));
		end
		return p[3] ? -v : v;
	endfunction

	// sample times table value, back to 20 bits
	function automatic logic signed [DAT_W-1:0] mul(input logic signed [DAT_W-1:0] x,
		input logic signed [7:0] c);
		logic signed [DAT_W+7:0] p;
		p = x * c;
		return DAT_W'(p >>> 7);
	endfunction

	// clamp to 20-bit signed range
	function automatic logic signed [DAT_W-1:0] sat(input logic signed [DAT_W+1:0] x);
		if (x > 22'sh07FFFF) begin
			return 20'sh7FFFF;
		end else if (x < -22'sh080000) begin
			return -20'sh80000;
		end
		return DAT_W'(x);
	endfunction

	// decimation code clamped to the legal range
	function automatic logic [2:0] dsel(input logic [31:0] c);
		return c[C_DEC +: 3] > DEC_MAX ? DEC_MAX : c[C_DEC +: 3];
	endfunction

	// mask keeping the top res bits of a 20-bit word
	function automatic logic [DAT_W-1:0] rmask(input logic [31:0] c);
		logic [4:0] res;
		res = c[C_RES +: 5];
		res = res < RES_MIN ? RES_MIN : (res > RES_MAX ? RES_MAX : res);
		return ~((20'h00001 << (RES_MAX - res)) - 20'h00001);
	endfunction

	// --------------------------------------------------------------------
	// next state
	// --------------------------------------------------------------------
	always_comb begin
		logic [31:0]              wm;
		logic signed [DAT_W-1:0]  s20, mi, mq, oi, oq, si;
		logic signed [7:0]        sn;
		logic [4:0]               last;
		logic [ACC_W-1:0]         ai, aq;
		r_next         = r_reg;
		r_next.restart = 1'b0;
		r_next.push_v  = 1'b0;
		wm  = merge(r_reg.ctrl, r_reg.wdata, r_reg.wstrb);
		s20 = '0;
		mi  = '0;
		mq  = '0;
		oi  = '0;
		oq  = '0;
		si  = '0;
		sn  = '0;
		ai  = '0;
		aq  = '0;
		last = 5'((6'h02 << dsel(r_reg.ctrl)) - 6'h01);
		// write address and data, taken in either order
		if (awvalid_i && r_reg.awrdy) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = awaddr_i;
		end
		if (wvalid_i && r_reg.wrdy) begin
			r_next.w_got = 1'b1;
			r_next.wdata = wdata_i;
			r_next.wstrb = wstrb_i;
		end
		if (bvalid_o && bready_i) begin
			r_next.bvalid = 1'b0;
		end
		// stream path; a window is dropped on restart or reconfiguration
		r_next.align_prev = powerdown_align_pin_i;
		if (restart_evt) begin
			r_next.nco_act = r_reg.nco_pend;
			r_next.phase   = '0;
			r_next.dcnt    = '0;
			r_next.fs4_k   = 1'b0;
		end else if (take) begin
			r_next.phase = r_reg.phase + r_reg.nco_act;
			s20 = {(r_reg.ctrl[C_SWAP] ? sample_b_i : sample_a_i), 6'h00};
			if (!r_reg.ctrl[C_EN]) begin
				r_next.push_v = 1'b1;
				r_next.push_d = {20'h00000, s20 & rmask(r_reg.ctrl)};
			end else begin
				if (r_reg.ctrl[C_REAL]) begin
					mi = s20;
				end else begin
					sn = sine(r_reg.phase[31:28]);
					mi = mul(s20, sine(r_reg.phase[31:28] + 4'h4));
					// negative exponential or inverted phase flips sign; both together cancel
					mq = mul(s20, (r_reg.ctrl[C_NEGX] ^ r_reg.ctrl[C_INV]) ? -sn : sn);
				end
				ai = r_reg.dcnt == '0 ? ACC_W'(mi) : r_reg.acc_i + ACC_W'(mi);
				aq = r_reg.dcnt == '0 ? ACC_W'(mq) : r_reg.acc_q + ACC_W'(mq);
				r_next.acc_i = ai;
				r_next.acc_q = aq;
				r_next.dcnt  = r_reg.dcnt + 5'h01;
				if (r_reg.dcnt == last) begin
					r_next.dcnt = '0;
					oi = DAT_W'($signed(ai) >>> (dsel(r_reg.ctrl) + 3'h1));
					oq = DAT_W'($signed(aq) >>> (dsel(r_reg.ctrl) + 3'h1));
					if (r_reg.ctrl[C_GAIN] && r_reg.ctrl[C_REAL]) begin
						// about 1.41 from shifts, no multiplier
						oi = sat(22'(oi) + 22'(oi >>> 2) + 22'(oi >>> 3) + 22'(oi >>> 5));
					end else if (r_reg.ctrl[C_GAIN]) begin
						oi = sat(22'(oi) <<< 1);
						oq = sat(22'(oq) <<< 1);
					end
					if (r_reg.ctrl[C_FS4] && !r_reg.ctrl[C_REAL]) begin
						// one word per output; q is negated on even outputs and i on odd outputs
						si = r_reg.fs4_k ? -oi : oi;
						oq = r_reg.fs4_k ? oq : -oq;
						oi = si;
						r_next.fs4_k = !r_reg.fs4_k;
					end
					r_next.push_v = 1'b1;
					r_next.push_d = {oq & rmask(r_reg.ctrl), oi & rmask(r_reg.ctrl)};
				end
			end
		end
		// register write once both halves are in
		if (r_reg.aw_got && r_reg.w_got) begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = RESP_OK;
			unique case (r_reg.awaddr)
				ADDR_CTRL: begin
					r_next.ctrl    = wm & ~(32'h1 << C_RESTART);
					r_next.restart = wm[C_RESTART];
					r_next.dcnt    = '0;
					r_next.fs4_k   = 1'b0;
				end
				ADDR_NCO: begin
					r_next.nco_pend = merge(r_reg.nco_pend, r_reg.wdata, r_reg.wstrb);
				end
				ADDR_NCO_ACT, ADDR_STAT: begin
					r_next.bresp = RESP_OK;  // read only, write ignored
				end
				default: begin
					r_next.bresp = RESP_DEC;
				end
			endcase
		end
		r_next.awrdy = !r_next.aw_got && !r_next.bvalid;
		r_next.wrdy  = !r_next.w_got && !r_next.bvalid;
		// read channel
		if (r_reg.rvalid && rready_i) begin
			r_next.rvalid = 1'b0;
		end
		if (arvalid_i && r_reg.ardy) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = RESP_OK;
			unique case (araddr_i)
				ADDR_CTRL:    r_next.rdata = r_reg.ctrl;
				ADDR_NCO:     r_next.rdata = r_reg.nco_pend;
				ADDR_NCO_ACT: r_next.rdata = r_reg.nco_act;
				ADDR_STAT:    r_next.rdata = {11'h000, r_reg.dcnt, 7'h00, r_reg.rdy,
					3'h0, lvl};
				default: begin
					r_next.rdata = '0;
					r_next.rresp = RESP_DEC;
				end
			endcase
		end
		r_next.ardy = !r_next.rvalid;
		// three words of room cover the push pipeline lag
		r_next.rdy = lvl < LVL_W'(FIFO_D - 3);
	end

	assign take        = sample_valid_i && r_reg.rdy;
	assign align_evt   = r_reg.ctrl[C_SYNCEN] && powerdown_align_pin_i && !r_reg.align_prev;
	assign restart_evt = r_reg.restart || align_evt;

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_reg          <= '0;
			r_reg.ctrl     <= CTRL_RST;
			r_reg.nco_pend <= NCO_RST;
			r_reg.nco_act  <= NCO_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// --------------------------------------------------------------------
	// output buffer
	// --------------------------------------------------------------------
	ddcv_fifo #(.W(2*DAT_W), .DEPTH(FIFO_D)) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (r_reg.push_v),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (r_reg.push_d),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  ({out_q_o, out_i_o}),
		.level_o     (lvl)
	);

	assign awready_o      = r_reg.awrdy;
	assign wready_o       = r_reg.wrdy;
	assign bvalid_o       = r_reg.bvalid;
	assign bresp_o        = r_reg.bresp;
	assign arready_o      = r_reg.ardy;
	assign rvalid_o       = r_reg.rvalid;
	assign rresp_o        = r_reg.rresp;
	assign rdata_o        = r_reg.rdata;
	assign sample_ready_o = r_reg.rdy;

	// --------------------------------------------------------------------
	// checks
	// --------------------------------------------------------------------
	a_nco_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		restart_evt |=> r_reg.nco_act == $past(r_reg.nco_pend))
		else $error("pending word not loaded on restart");
	a_nco_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!restart_evt |=> $stable(r_reg.nco_act))
		else $error("active word changed without restart");
	a_phase_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		align_evt |=> r_reg.phase == '0)
		else $error("sync did not clear phase");
	a_phase_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take && !restart_evt |=> r_reg.phase == $past(r_reg.phase) + $past(r_reg.nco_act))
		else $error("phase step wrong");
	a_bypass_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take && !restart_evt && !r_reg.ctrl[C_EN] |=> r_reg.push_v)
		else $error("bypass sample not pushed");
	a_dec_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.push_v && $past(r_reg.ctrl[C_EN]) |-> $past(r_reg.dcnt) ==
		5'((6'h02 << dsel($past(r_reg.ctrl))) - 6'h01))
		else $error("output outside window end");
	a_trunc_lsb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.push_v && $stable(r_reg.ctrl) |-> (r_reg.push_d[DAT_W-1:0] &
		~rmask(r_reg.ctrl)) == '0)
		else $error("low bits not truncated");
	a_real_q: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.push_v && $stable(r_reg.ctrl) && r_reg.ctrl[C_REAL] |->
		r_reg.push_d[2*DAT_W-1:DAT_W] == '0)
		else $error("real mode produced imaginary part");
	a_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.push_v |-> fifo_rdy)
		else $error("buffer push while full");
endmodule // ddcv_top

// [dv/ddcv_stream_model.sv]
`timescale 1ns/100ps
// sample source upstream and output sink downstream of the block
module ddcv_stream_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        go_i,           // start a burst
	input  wire logic [7:0]  burst_i,        // samples in the burst
	input  wire logic [13:0] smp_i,          // sample value offered
	input  wire logic        stall_i,        // sink holds off
	output logic      [13:0] sample_a_o,
	output logic      [13:0] sample_b_o,
	output logic             sample_valid_o,
	input  wire logic        sample_ready_i,
	input  wire logic        out_valid_i,
	output logic             out_ready_o,
	input  wire logic [19:0] out_i_i,
	input  wire logic [19:0] out_q_i,
	output logic      [15:0] n_in_o,         // samples taken
	output logic      [15:0] n_out_o,        // words taken
	output logic      [19:0] last_i_o,
	output logic      [19:0] last_q_o
);
	logic [7:0]  left;                       // samples still to send
	logic [13:0] held;                       // payload on offer
	// idle A line shows the inverse of the payload; B is always the inverse of A
	assign sample_valid_o = (left != 8'h00);
	assign sample_a_o     = sample_valid_o ? held : ~held;
	assign sample_b_o     = ~sample_a_o;
	// payload stays put for the whole burst; only go loads a new one
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			left        <= 8'h00;
			held        <= 14'h0000;
			n_in_o      <= 16'h0000;
			n_out_o     <= 16'h0000;
			out_ready_o <= 1'b0;
			last_i_o    <= 20'h00000;
			last_q_o    <= 20'h00000;
		end else begin
			out_ready_o <= !stall_i;
			if (go_i) begin
				left <= burst_i;
				held <= smp_i;
			end else if (sample_valid_o && sample_ready_i) begin
				left   <= left - 8'h01;
				n_in_o <= n_in_o + 16'h0001;
			end
			// sink records every word it accepts
			if (out_valid_i && out_ready_o) begin
				n_out_o  <= n_out_o + 16'h0001;
				last_i_o <= out_i_i;
				last_q_o <= out_q_i;
			end
		end
	end
endmodule // ddcv_stream_model

// [dv/ddcv_top_tb_top.sv]
`timescale 1ns/100ps
module ddcv_top_tb_top
	import ddcv_pkg::*;
;
	typedef struct {
		logic [7:0]  a;                      // register address
		logic [31:0] d;                      // word written
		logic [31:0] r;                      // word read back
		logic [1:0]  resp;                   // answer on both channels
		int          ns;                     // samples sent after
		int          no;                     // words expected out
	} ddcv_row_s;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic              clk_i, rst_n_i;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rd, w, wn;
	logic [3:0]        wstrb;
	logic              awvalid, wvalid, bready, arvalid, rready, pin, go, stall;
	logic [7:0]        burst;
	logic [13:0]       smp;
	logic [1:0]        resp;
	logic [15:0]       i0, o0;
	wire               awready, wready, bvalid, arready, rvalid, sready, svalid;
	wire               oready, ovalid;
	wire  [1:0]        bresp, rresp;
	wire  [31:0]       rdata;
	wire  [13:0]       sa, sb;
	wire  [19:0]       oi, oq, last_i, last_q;
	wire  [15:0]       n_in, n_out;
	int                fail_count, n_compared, t;
	// decimation rows: real by 2..32, complex, quarter-rate, clamps; then register access rows
	ddcv_row_s rows [12] = '{
		'{ADDR_CTRL, 32'h0014_0003, 32'h0014_0003, RESP_OK, 64, 32},
		'{ADDR_CTRL, 32'h0014_1003, 32'h0014_1003, RESP_OK, 64, 16},
		'{ADDR_CTRL, 32'h0014_2003, 32'h0014_2003, RESP_OK, 64, 8},
		'{ADDR_CTRL, 32'h0014_3003, 32'h0014_3003, RESP_OK, 64, 4},
		'{ADDR_CTRL, 32'h0014_4003, 32'h0014_4003, RESP_OK, 64, 2},
		'{ADDR_CTRL, 32'h0014_2001, 32'h0014_2001, RESP_OK, 64, 8},
		'{ADDR_CTRL, 32'h0014_1005, 32'h0014_1005, RESP_OK, 64, 16},
		'{ADDR_CTRL, 32'h001F_7003, 32'h001F_7003, RESP_OK, 64, 2},
		'{ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, RESP_OK, 0, 0},
		'{ADDR_NCO, 32'h1234_5678, 32'h1234_5678, RESP_OK, 0, 0},
		'{ADDR_NCO_ACT + 8'h00, 32'h0, 32'h0, RESP_OK, 0, 0},
		'{8'h10, 32'h0, 32'h0, RESP_DEC, 0, 0}
	};
	ddcv_top u_ddcv_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr),
		.awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
		.wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
		.bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
		.rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
		.sample_a_i(sa), .sample_b_i(sb), .sample_valid_i(svalid),
		.sample_ready_o(sready), .powerdown_align_pin_i(pin), .out_valid_o(ovalid),
		.out_ready_i(oready), .out_i_o(oi), .out_q_o(oq));
	ddcv_stream_model u_ddcv_stream_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.go_i(go), .burst_i(burst), .smp_i(smp), .stall_i(stall), .sample_a_o(sa),
		.sample_b_o(sb), .sample_valid_o(svalid), .sample_ready_i(sready),
		.out_valid_i(ovalid), .out_ready_o(oready), .out_i_i(oi), .out_q_i(oq),
		.n_in_o(n_in), .n_out_o(n_out), .last_i_o(last_i), .last_q_o(last_q));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// write: both halves offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic a1, w1, b1;
		int   n;
		b1 = 1'b0;
		@(posedge clk_i);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 200 && !b1; n++) begin
			// look between edges, act just after the edge
			@(negedge clk_i);
			a1 = awvalid && awready;
			w1 = wvalid && wready;
			b1 = bready && bvalid;
			r  = bresp;
			@(posedge clk_i);
			if (a1) awvalid <= 1'b0;
			if (w1) wvalid <= 1'b0;
			if (b1) bready <= 1'b0;
		end
		if (!b1) fail_count++;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic a1, r1;
		int   n;
		r1 = 1'b0;
		@(posedge clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 200 && !r1; n++) begin
			@(negedge clk_i);
			a1 = arvalid && arready;
			r1 = rready && rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clk_i);
			if (a1) arvalid <= 1'b0;
			if (r1) rready <= 1'b0;
		end
		if (!r1) fail_count++;
	endtask
	// send a burst, wait bounded for the expected word count
	task automatic stream(input int ns, input int no);
		o0 = n_out;
		@(posedge clk_i);
		burst <= ns[7:0];
		go    <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		for (t = 0; t < 3000 && n_out != o0 + no[15:0]; t++) @(posedge clk_i);
		repeat (40) @(posedge clk_i);
		chk(32'(n_out - o0), no, "words out");
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// whole run is a few thousand cycles; 40000 means a hang
	initial begin
		#1000000;
		fail_count++;
		end_sim();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pin, go, stall} = 8'h00;
		{awaddr, araddr, wdata, wstrb, burst} = 60'h0;
		smp     = 14'h0100;
		rst_n_i = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		foreach (rows[k]) begin
			axi_wr(rows[k].a, rows[k].d, resp);
			if (rows[k].a != ADDR_NCO_ACT) chk(32'(resp), 32'(rows[k].resp), "bresp");
			axi_rd(rows[k].a, rd, resp);
			chk(32'(resp), 32'(rows[k].resp), "rresp");
			if (rows[k].resp === RESP_OK) chk(rd, rows[k].r, "rdata");
			if (rows[k].ns > 0) stream(rows[k].ns, rows[k].no);
		end
		$display("table rows done");
		// load a nonzero active word so the reset has something to clear
		axi_wr(ADDR_CTRL, 32'h0000_0100, resp);
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, 32'h1234_5678, "active before reset");
		// second reset in mid-run: path off, words cleared
		rst_n_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		axi_rd(ADDR_CTRL, rd, resp);
		chk(rd, CTRL_RST, "ctrl reset");
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, NCO_RST, "active reset");
		axi_rd(ADDR_NCO, rd, resp);
		chk(rd, NCO_RST, "pending reset");
		$display("reset test done");
		// tuning words for +10 and -10 at a rate of 125, rounded
		w  = 32'(((64'd10 << 32) + 64'd62) / 64'd125);
		wn = 32'(((64'd115 << 32) + 64'd62) / 64'd125);
		axi_wr(ADDR_NCO, w, resp);
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, NCO_RST, "active before restart");
		axi_wr(ADDR_CTRL, 32'h0014_0101, resp);
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, w, "active after restart");
		axi_rd(ADDR_CTRL, rd, resp);
		chk(rd, 32'h0014_0001, "restart clears");
		axi_wr(ADDR_NCO, wn, resp);
		axi_wr(ADDR_CTRL, 32'h0014_0081, resp);
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, w, "active before sync");
		pin <= 1'b1;
		repeat (3) @(posedge clk_i);
		pin <= 1'b0;
		axi_rd(ADDR_NCO_ACT, rd, resp);
		chk(rd, wn, "active after sync");
		$display("oscillator test done");
		// swap: channel B slot feeds the path, model drives B as inverse of A
		smp <= 14'h2A5;
		axi_wr(ADDR_CTRL, 32'h0014_0010, resp);
		stream(1, 1);
		chk(32'(last_i), {12'h000, 14'h3D5A, 6'h00}, "swapped i");
		// real by 2 with gain: constant input scaled by 45/32
		axi_wr(ADDR_CTRL, 32'h0014_000B, resp);
		stream(2, 1);
		chk(32'(last_i), 32'd60930, "real gain i");
		chk(32'(last_q), 32'h0, "real gain q");
		$display("swap and gain test done");
		// bypass: sample lands in the top of the 20-bit word
		axi_wr(ADDR_CTRL, CTRL_RST, resp);
		smp <= 14'h2A5;
		stream(5, 5);
		chk(32'(last_i), {12'h000, 14'h2A5, 6'h00}, "bypass i");
		chk(32'(last_q), 32'h0, "bypass q");
		$display("bypass test done");
		// buffer: stall the sink until the source is refused
		stall <= 1'b1;
		i0 = n_in;
		o0 = n_out;
		@(posedge clk_i);
		burst <= 8'd40;
		go    <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (80) @(posedge clk_i);
		axi_rd(ADDR_STAT, rd, resp);
		chk(32'(rd[8]), 32'h0, "ready while full");
		chk(32'(n_in - i0 < 16'd40), 32'h1, "source refused");
		stall <= 1'b0;
		for (t = 0; t < 3000 && n_in - i0 != 16'd40; t++) @(posedge clk_i);
		repeat (60) @(posedge clk_i);
		chk(32'(n_out - o0), 32'd40, "all words drained");
		axi_rd(ADDR_STAT, rd, resp);
		chk(32'(rd[4:0]), 32'h0, "buffer empty");
		$display("buffer test done");
		end_sim();
	end
endmodule // ddcv_top_tb_top
